/* inc/wkil_pkg.sv */
// Package for the wake input and interrupt logic block
package wkil_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned FILTER_MIN_US = 12;
  localparam int unsigned FILTER_CYC = FILTER_MIN_US * CLK_MHZ;
  localparam int unsigned PULSE_TYP_US = 100;
  localparam int unsigned PULSE_CYC = PULSE_TYP_US * CLK_MHZ;
  localparam int unsigned GAP_TYP_US = 100;
  localparam int unsigned GAP_CYC = GAP_TYP_US * CLK_MHZ;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT_FIRST = 8'h04;
  localparam logic [7:0] ADDR_STAT_THIRD = 8'h08;
  localparam logic [7:0] ADDR_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_SRC = 8'h10;

  // Control field positions
  localparam int unsigned CTRL_WAKE_EN_BIT = 0;
  localparam int unsigned CTRL_CONV_SEL_BIT = 1;
  localparam int unsigned CTRL_PULL_LSB = 2;
  localparam int unsigned CTRL_SRC_EN_LSB = 8;
  localparam int unsigned CTRL_STOP_CMD_BIT = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;

  // Status bit positions
  localparam int unsigned STAT_PIN_WAKE_BIT = 0;
  localparam int unsigned STAT_TIMEOUT_BIT = 0;
  localparam int unsigned STAT_BATT_BIT = 1;
  localparam int unsigned STAT_CONV_BIT = 2;

  typedef enum logic [2:0] {
    WKIL_NORMAL = 3'b000,
    WKIL_STOP = 3'b001,
    WKIL_SLEEP = 3'b010,
    WKIL_FAILSAFE = 3'b011,
    WKIL_RESTART = 3'b100
  } wkil_mode_e;

  typedef enum logic [1:0] {
    WKIL_IDLE = 2'b00,
    WKIL_PULSE = 2'b01,
    WKIL_GAP = 2'b10
  } wkil_int_e;

  typedef struct packed {
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
  } wkil_ahb_req_s;

  typedef struct packed {
    logic pull_up;
    logic pull_down;
  } wkil_pull_s;
endpackage

/* verilog/wkil_top.sv */
// Wake pin detection, event latching and interrupt pulse generation
// Operation
// - Both rising and falling wake pin edges are wake events.
// - Event interrupts in Normal/Stop, wakes chip in Sleep/Fail-Safe.
// - Wake from Sleep only when the wake pin enable bit is one.
// - Normal/Stop interrupt only after the level passes the filter.
// - Fail-Safe: any edge requests Restart regardless of enable.
// - Pin wake recorded in flag of first wake status register.
// - Present pin level readable in Normal and Stop mode.
// - Converter select: low picks PFM, high PWM, unfiltered, stay Stop.
// - Converter select still lets pin wake Sleep into Normal.
// - Pull field: none, down, up, or automatic follow of level.
// - Pull field resets to no current.
// - Output stays high at least the minimum gap between pulses.
// - Interrupt pulse never changes the operating mode.
// - Pulse on wake status, unmasked timeout, battery, PFM-to-PWM.
// - Source interrupts only if enabled as a wake source.
// - Level register never interrupts and is not latched.
// - Entering Stop with uncleared wake status issues a pulse.
// - Status registers update at each interrupt falling edge.
// - Events held until host clears them by write.
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
module wkil_top #(
  parameter int unsigned FILTER_CYC = wkil_pkg::FILTER_CYC,
  parameter int unsigned PULSE_CYC = wkil_pkg::PULSE_CYC,
  parameter int unsigned GAP_CYC = wkil_pkg::GAP_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic wake_pin_i,
  input wire logic [2:0] mode_i,
  input wire logic bus_timeout_flag_i,
  input wire logic battery_sense_event_i,
  input wire logic auto_pfm_to_pwm_i,
  output logic interrupt_out_n_o,
  output logic wake_request_o,
  output logic restart_request_o,
  output logic converter_pwm_o,
  output logic pull_up_en_o,
  output logic pull_down_en_o
);
  localparam int unsigned CW = 16;

  wkil_pkg::wkil_mode_e mode;
  assign mode = wkil_pkg::wkil_mode_e'(mode_i);

  // Bus address phase capture
  logic dp_write;
  logic dp_read;
  logic [7:0] dp_addr;
  wire addr_valid = hsel_i && hready_i && htrans_i[1];

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_write <= addr_valid && hwrite_i;
      dp_read <= addr_valid && !hwrite_i;
      dp_addr <= haddr_i[7:0];
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  wire wr_ctrl = dp_write && (dp_addr == wkil_pkg::ADDR_CTRL);
  wire wr_stat1 = dp_write && (dp_addr == wkil_pkg::ADDR_STAT_FIRST);
  wire wr_stat3 = dp_write && (dp_addr == wkil_pkg::ADDR_STAT_THIRD);

  // Control register
  logic [31:0] ctrl;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl <= wkil_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= hwdata_i;
    end
  end

  wire wake_pin_enable = ctrl[wkil_pkg::CTRL_WAKE_EN_BIT];
  wire pin_selects_converter_mode = ctrl[wkil_pkg::CTRL_CONV_SEL_BIT];
  wire [1:0] pull_select_control = ctrl[wkil_pkg::CTRL_PULL_LSB +: 2];
  wire [2:0] src_en = ctrl[wkil_pkg::CTRL_SRC_EN_LSB +: 3];
  wire stop_cmd = wr_ctrl && hwdata_i[wkil_pkg::CTRL_STOP_CMD_BIT];

  // Pin edge detection and filter
  logic pin_d;
  logic pin_primed;
  logic pin_stable;
  logic [CW-1:0] filt_cnt;
  // Pin idle level is unknown, so the first sample is no edge
  wire pin_edge = pin_primed && (wake_pin_i ^ pin_d);
  wire run_modes = (mode == wkil_pkg::WKIL_NORMAL) ||
                   (mode == wkil_pkg::WKIL_STOP);
  wire filt_done = (pin_stable != pin_d) &&
                   (filt_cnt == CW'(FILTER_CYC - 1));

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_d <= 1'b0;
      pin_primed <= 1'b0;
      pin_stable <= 1'b0;
      filt_cnt <= '0;
    end else begin
      pin_d <= wake_pin_i;
      pin_primed <= 1'b1;
      if (!pin_primed) begin
        pin_stable <= wake_pin_i;
        filt_cnt <= '0;
      end else if (filt_done) begin
        // Filtered level kept even if the pin moves again now
        pin_stable <= pin_d;
        filt_cnt <= '0;
      end else if (pin_edge || pin_stable == pin_d) begin
        filt_cnt <= '0;
      end else begin
        filt_cnt <= filt_cnt + CW'(1);
      end
    end
  end

  // Wake and restart requests
  wire sleep_wake = (mode == wkil_pkg::WKIL_SLEEP) && pin_edge &&
                    wake_pin_enable;
  wire fs_wake = (mode == wkil_pkg::WKIL_FAILSAFE) && pin_edge;
  wire run_event = run_modes && filt_done && wake_pin_enable;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wake_request_o <= 1'b0;
      restart_request_o <= 1'b0;
      converter_pwm_o <= 1'b0;
    end else begin
      wake_request_o <= sleep_wake;
      restart_request_o <= fs_wake;
      if (mode == wkil_pkg::WKIL_STOP && pin_selects_converter_mode) begin
        converter_pwm_o <= wake_pin_i;
      end else if (auto_pfm_to_pwm_i) begin
        converter_pwm_o <= 1'b1;
      end
    end
  end

  // Pull current select
  wire auto_pull = pull_select_control == wkil_pkg::PULL_AUTO;
  assign pull_up_en_o = (pull_select_control == wkil_pkg::PULL_UP) ||
                        (auto_pull && pin_d);
  assign pull_down_en_o = (pull_select_control == wkil_pkg::PULL_DOWN) ||
                          (auto_pull && !pin_d);

  // Pending events, latched into visible status at pulse start
  logic pend_pin;
  logic [2:0] pend_third;
  logic [31:0] stat_first;
  logic [31:0] stat_third;
  logic pulse_start;
  wire pin_set = run_event || sleep_wake || fs_wake;
  wire [2:0] third_set = {auto_pfm_to_pwm_i && mode == wkil_pkg::WKIL_STOP,
                          battery_sense_event_i,
                          bus_timeout_flag_i} & src_en;
  wire stat_nonzero = (stat_first != 32'h0) || (stat_third != 32'h0);
  wire [31:0] stat_first_clr = wr_stat1 ? ~hwdata_i : 32'hFFFF_FFFF;
  wire [31:0] stat_third_clr = wr_stat3 ? ~hwdata_i : 32'hFFFF_FFFF;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_pin <= 1'b0;
      pend_third <= 3'h0;
      stat_first <= 32'h0;
      stat_third <= 32'h0;
    end else begin
      // Set wins over clear so no event is lost
      if (pulse_start) begin
        pend_pin <= pin_set;
        pend_third <= third_set;
        stat_first <= (stat_first & stat_first_clr) |
                      {31'h0, pend_pin};
        stat_third <= (stat_third & stat_third_clr) | {29'h0, pend_third};
      end else begin
        pend_pin <= pend_pin | pin_set;
        pend_third <= pend_third | third_set;
        stat_first <= stat_first & stat_first_clr;
        stat_third <= stat_third & stat_third_clr;
      end
    end
  end

  // Interrupt pulse engine; no mode output exists here
  wkil_pkg::wkil_int_e int_state;
  logic [CW-1:0] int_cnt;
  logic stop_req;
  wire want_int = run_modes && (pend_pin || pend_third != 3'h0 || stop_req);
  wire cnt_pulse_end = int_cnt == CW'(PULSE_CYC - 1);
  wire cnt_gap_end = int_cnt == CW'(GAP_CYC - 1);
  assign pulse_start = (int_state == wkil_pkg::WKIL_IDLE) && want_int;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      int_state <= wkil_pkg::WKIL_IDLE;
      int_cnt <= '0;
      stop_req <= 1'b0;
    end else begin
      if (stop_cmd && stat_nonzero) begin
        stop_req <= 1'b1;
      end else if (pulse_start) begin
        stop_req <= 1'b0;
      end
      case (int_state)
        wkil_pkg::WKIL_IDLE: begin
          int_cnt <= '0;
          if (want_int) begin
            int_state <= wkil_pkg::WKIL_PULSE;
          end
        end
        wkil_pkg::WKIL_PULSE: begin
          if (cnt_pulse_end) begin
            int_state <= wkil_pkg::WKIL_GAP;
            int_cnt <= '0;
          end else begin
            int_cnt <= int_cnt + CW'(1);
          end
        end
        wkil_pkg::WKIL_GAP: begin
          if (cnt_gap_end) begin
            int_state <= wkil_pkg::WKIL_IDLE;
            int_cnt <= '0;
          end else begin
            int_cnt <= int_cnt + CW'(1);
          end
        end
        default: begin
          int_state <= wkil_pkg::WKIL_IDLE;
          int_cnt <= '0;
        end
      endcase
    end
  end

  assign interrupt_out_n_o = int_state != wkil_pkg::WKIL_PULSE;

  // Read path; level register is live, never latched
  logic [31:0] rd_mux;
  wire [31:0] level_word = {31'h0, run_modes && pin_d};
  always_comb begin
    case (dp_addr)
      wkil_pkg::ADDR_CTRL: rd_mux = ctrl;
      wkil_pkg::ADDR_STAT_FIRST: rd_mux = stat_first;
      wkil_pkg::ADDR_STAT_THIRD: rd_mux = stat_third;
      wkil_pkg::ADDR_LEVEL: rd_mux = level_word;
      wkil_pkg::ADDR_SRC: rd_mux = {30'h0, pend_third != 3'h0, pend_pin};
      default: rd_mux = 32'h0;
    endcase
  end
  assign hrdata_o = dp_read ? rd_mux : 32'h0;

  // Checks
  property p_pulse_width;
    @(posedge sys_clk_i) disable iff (reset_i)
    $fell(interrupt_out_n_o) |-> !interrupt_out_n_o [*8];
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("interrupt pulse too short");

  property p_gap;
    @(posedge sys_clk_i) disable iff (reset_i)
    $rose(interrupt_out_n_o) |-> interrupt_out_n_o [*8];
  endproperty
  a_gap: assert property (p_gap)
    else $error("interrupt gap too short");

  property p_fs_restart;
    @(posedge sys_clk_i) disable iff (reset_i)
    fs_wake |=> restart_request_o;
  endproperty
  a_fs_restart: assert property (p_fs_restart)
    else $error("fail-safe edge did not request restart");

  property p_sleep_en;
    @(posedge sys_clk_i) disable iff (reset_i)
    (mode == wkil_pkg::WKIL_SLEEP && !wake_pin_enable) |=> !wake_request_o;
  endproperty
  a_sleep_en: assert property (p_sleep_en)
    else $error("wake without enable");

  property p_pull_excl;
    @(posedge sys_clk_i) disable iff (reset_i)
    !(pull_up_en_o && pull_down_en_o);
  endproperty
  a_pull_excl: assert property (p_pull_excl)
    else $error("pull up and down together");

  property p_stat_at_fall;
    @(posedge sys_clk_i) disable iff (reset_i)
    (pend_pin && pulse_start) |=> stat_first[wkil_pkg::STAT_PIN_WAKE_BIT];
  endproperty
  a_stat_at_fall: assert property (p_stat_at_fall)
    else $error("status not updated at pulse start");

  property p_no_int_sleep;
    @(posedge sys_clk_i) disable iff (reset_i)
    (int_state == wkil_pkg::WKIL_IDLE && !run_modes) |=> interrupt_out_n_o;
  endproperty
  a_no_int_sleep: assert property (p_no_int_sleep)
    else $error("interrupt outside run modes");

  property p_conv;
    @(posedge sys_clk_i) disable iff (reset_i)
    (mode == wkil_pkg::WKIL_STOP && pin_selects_converter_mode)
      |=> converter_pwm_o == $past(wake_pin_i);
  endproperty
  a_conv: assert property (p_conv)
    else $error("converter select does not follow pin");

  // Exact lengths counted, since repetition counts stay small
  logic [CW-1:0] low_len;
  logic [CW-1:0] high_len;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_len <= '0;
      high_len <= '1;
    end else begin
      low_len <= interrupt_out_n_o ? '0 : low_len + CW'(1);
      if (!interrupt_out_n_o) begin
        high_len <= '0;
      end else if (high_len != '1) begin
        high_len <= high_len + CW'(1);
      end
    end
  end

  property p_pulse_exact;
    @(posedge sys_clk_i) disable iff (reset_i)
    $rose(interrupt_out_n_o) |-> low_len == CW'(PULSE_CYC);
  endproperty
  a_pulse_exact: assert property (p_pulse_exact)
    else $error("interrupt pulse length wrong");

  property p_gap_min;
    @(posedge sys_clk_i) disable iff (reset_i)
    $fell(interrupt_out_n_o) |-> high_len >= CW'(GAP_CYC);
  endproperty
  a_gap_min: assert property (p_gap_min)
    else $error("interrupt gap below minimum");

  property p_stat_kept;
    @(posedge sys_clk_i) disable iff (reset_i)
    (!wr_stat1 && !wr_stat3) |=>
      ((stat_first & $past(stat_first)) == $past(stat_first)) &&
      ((stat_third & $past(stat_third)) == $past(stat_third));
  endproperty
  a_stat_kept: assert property (p_stat_kept)
    else $error("status bit lost without clear");

  property p_pend_kept;
    @(posedge sys_clk_i) disable iff (reset_i)
    pin_set |=> pend_pin;
  endproperty
  a_pend_kept: assert property (p_pend_kept)
    else $error("pin event dropped");

  property p_stop_req;
    @(posedge sys_clk_i) disable iff (reset_i)
    (stop_cmd && stat_nonzero) |=> stop_req;
  endproperty
  a_stop_req: assert property (p_stop_req)
    else $error("stop command with status not queued");

  property p_wake_edge;
    @(posedge sys_clk_i) disable iff (reset_i)
    sleep_wake |=> wake_request_o;
  endproperty
  a_wake_edge: assert property (p_wake_edge)
    else $error("enabled sleep edge did not wake");
endmodule

/* verif/wkil_host_model.sv */
// Host side model: watches the interrupt line and times its pulses
module wkil_host_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic int_n_i,
  output logic [7:0] pulse_count_o,
  output logic [15:0] width_o,
  output logic [15:0] gap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run;
  logic prev;
  // Sampled like a slow port pin, so only whole cycles are seen
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev <= 1'b1;
      run <= 16'h0000;
      pulse_count_o <= 8'h00;
      width_o <= 16'h0000;
      gap_o <= 16'h0000;
    end else begin
      prev <= int_n_i;
      if (int_n_i !== prev) begin
        run <= 16'h0001;
        if (int_n_i === 1'b0) begin
          pulse_count_o <= pulse_count_o + 8'h01;
          gap_o <= run;
        end else begin
          width_o <= run;
        end
      end else begin
        run <= run + 16'h0001;
      end
    end
  end
endmodule

/* verif/tb.sv */
// Testbench for the wake input and interrupt logic
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, pin = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] mode = 3'h0;
  logic tmo = 1'b0, bat = 1'b0, pfm = 1'b0;
  logic hrdy, hresp, int_n, wk_req, rs_req, pwm, pu, pd, wk_seen, rs_seen;
  logic [7:0] h_cnt;
  logic [15:0] h_w, h_g;
  int mismatches = 0, num_checks = 0;
  always #4 clk = ~clk;
  wkil_top #(.FILTER_CYC(20), .PULSE_CYC(50), .GAP_CYC(50)) u_dut (
    .sys_clk_i(clk), .reset_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .wake_pin_i(pin),
    .mode_i(mode), .bus_timeout_flag_i(tmo),
    .battery_sense_event_i(bat), .auto_pfm_to_pwm_i(pfm),
    .interrupt_out_n_o(int_n), .wake_request_o(wk_req),
    .restart_request_o(rs_req), .converter_pwm_o(pwm),
    .pull_up_en_o(pu), .pull_down_en_o(pd));
  wkil_host_model u_host (.clk_i(clk), .reset_i(rst), .int_n_i(int_n),
    .pulse_count_o(h_cnt), .width_o(h_w), .gap_o(h_g));
  // Sticky catch of the one-cycle request pulses
  always @(posedge clk) begin
    if (wk_req === 1'b1) wk_seen <= 1'b1;
    if (rs_req === 1'b1) rs_seen <= 1'b1;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(nm, x, e);
    chk("okay response", {31'h0, hresp}, 32'h0);
  endtask
  task automatic ev(input logic [2:0] sel);
    @(posedge clk);
    {pfm, bat, tmo} <= sel;
    @(posedge clk);
    {pfm, bat, tmo} <= 3'h0;
  endtask
  task automatic wait_cnt(input logic [7:0] n);
    for (int i = 0; i < 400 && h_cnt !== n; i++) @(posedge clk);
    chk("pulse count", {24'h0, h_cnt}, {24'h0, n});
  endtask
  task automatic toggle(input int cyc);
    @(posedge clk);
    pin <= ~pin;
    repeat (cyc) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    wk_seen = 1'b0;
    rs_seen = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc("ctrl reset", 8'h00, 32'h0);
    chk("pulls reset", {30'h0, pu, pd}, 32'h0);
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, p << 2);
      for (int l = 0; l < 2; l++) begin
        toggle(3);
        chk("pull up", pu, p == 2 || (p == 3 && pin));
        chk("pull down", pd, p == 1 || (p == 3 && !pin));
        rdc("level", 8'h0C, {31'h0, pin});
      end
    end
    chk("no pulse yet", {24'h0, h_cnt}, 32'h0);
    $display("test pulls done");
    wr(8'h00, 32'h0000_0101);
    toggle(5);
    toggle(5);
    chk("glitch", {24'h0, h_cnt}, 32'h0);
    toggle(10);
    chk("filter hold", {24'h0, h_cnt}, 32'h0);
    wait_cnt(8'd1);
    rdc("pin flag", 8'h04, 32'h1);
    ev(3'h1);
    wait_cnt(8'd2);
    chk("width", {16'h0, h_w}, 32'd50);
    chk("gap ok", {31'h0, h_g >= 16'd50}, 32'h1);
    rdc("timeout flag", 8'h08, 32'h1);
    chk("no wake", {30'h0, wk_seen, rs_seen}, 32'h0);
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h1);
    rdc("clear first", 8'h04, 32'h0);
    rdc("clear third", 8'h08, 32'h0);
    toggle(1);
    wait_cnt(8'd3);
    rdc("fall flag", 8'h04, 32'h1);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h1);
    ev(3'h1);
    repeat (150) @(posedge clk);
    chk("masked", {24'h0, h_cnt}, 32'd3);
    $display("test interrupts done");
    wr(8'h00, 32'h0000_0201);
    ev(3'h2);
    wait_cnt(8'd4);
    mode <= 3'h1;
    wr(8'h00, 32'h0001_0201);
    wait_cnt(8'd5);
    wr(8'h08, 32'h2);
    wr(8'h00, 32'h2);
    for (int l = 0; l < 2; l++) begin
      toggle(3);
      chk("converter", pwm, pin);
      rdc("stop level", 8'h0C, {31'h0, pin});
    end
    wr(8'h00, 32'h0000_0400);
    ev(3'h4);
    wait_cnt(8'd6);
    chk("auto pwm", pwm, 1'b1);
    rdc("pfm flag", 8'h08, 32'h4);
    repeat (120) @(posedge clk);
    chk("stop count", {24'h0, h_cnt}, 32'd6);
    $display("test stop done");
    mode <= 3'h2;
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, c);
      wk_seen <= 1'b0;
      toggle(40);
      chk("sleep wake", wk_seen, c[0]);
    end
    mode <= 3'h3;
    wr(8'h00, 32'h0);
    toggle(40);
    chk("restart", rs_seen, 1'b1);
    $display("test wake done");
    end_of_test;
  end
  initial begin
    #300000;
    mismatches++;
    end_of_test;
  end
endmodule
